// >>> hdl/ims_params.svh
// Purpose: constants of the two-wire bus master sequencer (offsets, fields, timing)
// Assumes: included by the package and by the design modules by bare name
// Notes: definitions only, no logic
//
// Behaviour
// - acknowledge phase drives the ack value bit
// - ack request runs ack sequence, self-clears
// - receive request clocks in one byte, self-clears
// - stop request makes Stop, self-clears
// - restart request makes Repeated Start, self-clears
// - start request makes Start, self-clears
// - request bits read zero when idle
`ifndef IMS_PARAMS_SVH
`define IMS_PARAMS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define IMS_ADDR_W 4
`define IMS_DATA_W 16
`define IMS_OFS_CTRL 4'h0
`define IMS_OFS_RXDATA 4'h2
`define IMS_CTRL_RESET 16'h0000
`define IMS_RXDATA_RESET 8'h00

// ****************************************************************
// control register fields
// ****************************************************************
`define IMS_BIT_START 0
`define IMS_BIT_RESTART 1
`define IMS_BIT_STOP 2
`define IMS_BIT_RECV 3
`define IMS_BIT_ACK 4
`define IMS_BIT_ACKVAL 5
`define IMS_REQ_W 5

// ****************************************************************
// link timing (quarter bit period in link clocks)
// ****************************************************************
`define IMS_QTR_TICKS 78
`define IMS_QTR_W 12
`define IMS_BITS_PER_BYTE 3'h7

`endif

// >>> hdl/ims_pkg.sv
// Purpose: types of the two-wire bus master sequencer
// Assumes: constants come from ims_params.svh
// Notes: one state struct per clock domain plus the synchroniser state
`include "ims_params.svh"

package ims_pkg;

    // ****************************************************************
    // sequencer states, gray along idle -> run -> done; done -> idle flips both bits
    // ****************************************************************
    typedef enum logic [1:0] {
        IMS_ST_IDLE = 2'h0,
        IMS_ST_RUN = 2'h1,
        IMS_ST_DONE = 2'h3
    } ims_seq_t;

    // register-side state (ref_clk domain)
    typedef struct packed {
        logic [`IMS_REQ_W-1:0] pend;     // request bits still in progress
        logic ack_val;                   // ack value select bit
        logic req_ack;                   // ack value frozen with the request
        logic [7:0] rx_byte;             // last received byte
        logic req_tgl;                   // request event toggle to the link
        logic [`IMS_DATA_W-1:0] rdata;   // read data register
    } ims_reg_state_t;

    // link-side state (link_clk domain)
    typedef struct packed {
        ims_seq_t st;                    // sequencer state
        logic [`IMS_REQ_W-1:0] cmd;      // one-hot running request
        logic ack_val;                   // ack value for this sequence
        logic [1:0] phase;               // quarter of the bit period
        logic [`IMS_QTR_W-1:0] qcnt;     // link clocks within the quarter
        logic [2:0] bitcnt;              // received bit index
        logic [7:0] shift;               // receive shift register
        logic done_tgl;                  // completion toggle to ref domain
        logic scl_low;                   // pulling the clock line low
        logic sda_low;                   // pulling the data line low
    } ims_link_state_t;

    // two-stage synchroniser plus edge stage
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } ims_sync_state_t;

endpackage : ims_pkg

// >>> hdl/ims_sync.sv
// Purpose: two flip-flop synchroniser with a change detector behind it
// Assumes: d is a level or a toggle from another domain
// Notes: stage one feeds only stage two; edge_p pulses once per toggle
`timescale 1ns/1ps
`include "ims_params.svh"

module ims_sync
    import ims_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic d,
    output logic q,
    output logic edge_p
);

    ims_sync_state_t s_reg; // synchroniser stages
    ims_sync_state_t s_next; // next stages

    // ****************************************************************
    // shift the stages while enabled
    // ****************************************************************
    always_comb begin
        s_next = s_reg;
        if (ce) begin
            s_next.s1 = d;
            s_next.s2 = s_reg.s1;
            s_next.s3 = s_reg.s2;
        end
        if (!rst_n) begin
            s_next = '0;
        end
    end

    // register the stages
    always_ff @(posedge clk) begin
        s_reg <= s_next;
    end

    assign q = s_reg.s2; // synchronised level
    assign edge_p = s_reg.s2 ^ s_reg.s3; // one pulse per change

endmodule : ims_sync

// >>> hdl/ims_master_seq.sv
// Purpose: master-side Start / Restart / Stop / receive / ack sequencer
// Assumes: registers on ref_clk, bus timing on link_clk, open-drain pins
// Notes: request bits self-clear when the link reports completion
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "ims_params.svh"

module ims_master_seq
    import ims_pkg::*;
#(
    parameter int QTR_TICKS = `IMS_QTR_TICKS
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [`IMS_ADDR_W-1:0] reg_addr,
    input wire logic [`IMS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`IMS_DATA_W-1:0] reg_rdata,
    input wire logic link_clk,
    input wire logic scl_in,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_o,
    output logic sda_oe
);

    localparam logic [`IMS_QTR_W-1:0] QTR_LAST = `IMS_QTR_W'(QTR_TICKS - 1);

    // ****************************************************************
    // helper functions
    // ****************************************************************

    // true when exactly one request bit is set
    function automatic logic one_hot(input logic [`IMS_REQ_W-1:0] v);
        logic [2:0] cnt;
        cnt = 3'h0;
        for (int i = 0; i < `IMS_REQ_W; i++) begin
            cnt = cnt + {2'h0, v[i]};
        end
        return cnt == 3'h1;
    endfunction : one_hot

    // read multiplexer of the register map
    function automatic logic [`IMS_DATA_W-1:0] read_word(
        input logic [`IMS_ADDR_W-1:0] addr,
        input ims_reg_state_t r
    );
        logic [`IMS_DATA_W-1:0] w;
        w = 16'h0000;
        if (addr == `IMS_OFS_CTRL) begin
            w[`IMS_REQ_W-1:0] = r.pend;
            w[`IMS_BIT_ACKVAL] = r.ack_val;
        end else if (addr == `IMS_OFS_RXDATA) begin
            w[7:0] = r.rx_byte;
        end
        return w;
    endfunction : read_word

    // ****************************************************************
    // declarations
    // ****************************************************************
    ims_reg_state_t r_reg; // register-side state
    ims_reg_state_t r_next; // its next value
    ims_link_state_t l_reg; // link-side state
    ims_link_state_t l_next; // its next value

    logic done_evt; // link finished a sequence (ref domain pulse)
    logic req_evt; // new request arrived (link domain pulse)
    logic l_rst_n; // reset seen in the link domain
    logic l_ce; // clock enable seen in the link domain
    logic scl_s; // synchronised clock line
    logic sda_s; // synchronised data line
    logic tick; // end of a quarter bit
    logic stretch; // target holds the clock line low
    logic fin; // last quarter of the running sequence

    // ****************************************************************
    // crossings
    // ****************************************************************

    // reset into the link domain
    ims_sync u_rst_sync (
        .clk(link_clk),
        .rst_n(1'h1),
        .ce(1'h1),
        .d(rst_n),
        .q(l_rst_n),
        .edge_p()
    );

    // clock enable into the link domain
    ims_sync u_ce_sync (
        .clk(link_clk),
        .rst_n(l_rst_n),
        .ce(1'h1),
        .d(ce),
        .q(l_ce),
        .edge_p()
    );

    // request toggle into the link domain
    ims_sync u_req_sync (
        .clk(link_clk),
        .rst_n(l_rst_n),
        .ce(l_ce),
        .d(r_reg.req_tgl),
        .q(),
        .edge_p(req_evt)
    );

    // completion toggle back to the register side
    ims_sync u_done_sync (
        .clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .d(l_reg.done_tgl),
        .q(),
        .edge_p(done_evt)
    );

    // clock line input
    ims_sync u_scl_sync (
        .clk(link_clk),
        .rst_n(l_rst_n),
        .ce(l_ce),
        .d(scl_in),
        .q(scl_s),
        .edge_p()
    );

    // data line input
    ims_sync u_sda_sync (
        .clk(link_clk),
        .rst_n(l_rst_n),
        .ce(l_ce),
        .d(sda_in),
        .q(sda_s),
        .edge_p()
    );

    // ****************************************************************
    // register side
    // ****************************************************************

    // request bits, ack value and read port
    always_comb begin
        r_next = r_reg;
        if (ce) begin
            // completion clears the pending bit and takes the byte
            if (done_evt) begin
                r_next.pend = '0;
                r_next.rx_byte = l_reg.shift;
            end
            if (reg_wr && reg_addr == `IMS_OFS_CTRL) begin
                r_next.ack_val = reg_wdata[`IMS_BIT_ACKVAL];
                // one request at a time, a new one wins over the clear
                if ((r_reg.pend == '0 || done_evt)
                    && one_hot(reg_wdata[`IMS_REQ_W-1:0])) begin
                    r_next.pend = reg_wdata[`IMS_REQ_W-1:0];
                    r_next.req_ack = reg_wdata[`IMS_BIT_ACKVAL];
                    r_next.req_tgl = ~r_reg.req_tgl;
                end
            end
            // read data stand for one cycle only
            if (reg_rd) begin
                r_next.rdata = read_word(reg_addr, r_reg);
            end else begin
                r_next.rdata = 16'h0000;
            end
        end
        if (!rst_n) begin
            r_next = '0;
            r_next.rx_byte = `IMS_RXDATA_RESET;
        end
    end

    // register side flip-flops
    always_ff @(posedge ref_clk) begin
        r_reg <= r_next;
    end

    assign reg_rdata = r_reg.rdata;

    // ****************************************************************
    // link side sequencer
    // ****************************************************************

    assign tick = l_reg.qcnt == QTR_LAST;
    assign stretch = !l_reg.scl_low && !scl_s;

    // finishing quarter of each sequence
    always_comb begin
        fin = 1'h0;
        if (l_reg.cmd[`IMS_BIT_START]) begin
            fin = l_reg.phase == 2'h1;
        end else if (l_reg.cmd[`IMS_BIT_STOP]) begin
            fin = l_reg.phase == 2'h2;
        end else if (l_reg.cmd[`IMS_BIT_RECV]) begin
            fin = l_reg.phase == 2'h3 && l_reg.bitcnt == `IMS_BITS_PER_BYTE;
        end else begin
            fin = l_reg.phase == 2'h3;
        end
    end

    // quarter-bit stepping of the bus lines
    always_comb begin
        l_next = l_reg;
        if (l_ce) begin
            unique case (l_reg.st)
                IMS_ST_IDLE: begin
                    // take the frozen request word
                    if (req_evt) begin
                        l_next.cmd = r_reg.pend;
                        l_next.ack_val = r_reg.req_ack;
                        l_next.phase = 2'h0;
                        l_next.qcnt = '0;
                        l_next.bitcnt = 3'h0;
                        l_next.st = IMS_ST_RUN;
                    end
                end
                IMS_ST_RUN: begin
                    if (!tick) begin
                        l_next.qcnt = l_reg.qcnt + `IMS_QTR_W'(1);
                    end else if (!stretch) begin
                        l_next.qcnt = '0;
                        l_next.phase = l_reg.phase + 2'h1;
                        // start: data falls, then clock falls
                        if (l_reg.cmd[`IMS_BIT_START]) begin
                            if (l_reg.phase == 2'h0) l_next.sda_low = 1'h1;
                            if (l_reg.phase == 2'h1) l_next.scl_low = 1'h1;
                        end
                        // restart: release data, raise clock, data falls, clock falls
                        if (l_reg.cmd[`IMS_BIT_RESTART]) begin
                            unique case (l_reg.phase)
                                2'h0: l_next.sda_low = 1'h0;
                                2'h1: l_next.scl_low = 1'h0;
                                2'h2: l_next.sda_low = 1'h1;
                                2'h3: l_next.scl_low = 1'h1;
                            endcase
                        end
                        // stop: data low, clock rises, data rises
                        if (l_reg.cmd[`IMS_BIT_STOP]) begin
                            if (l_reg.phase == 2'h0) l_next.sda_low = 1'h1;
                            if (l_reg.phase == 2'h1) l_next.scl_low = 1'h0;
                            if (l_reg.phase == 2'h2) l_next.sda_low = 1'h0;
                        end
                        // receive: release data, clock high, sample, clock low
                        if (l_reg.cmd[`IMS_BIT_RECV]) begin
                            unique case (l_reg.phase)
                                2'h0: l_next.sda_low = 1'h0;
                                2'h1: l_next.scl_low = 1'h0;
                                2'h2: l_next.shift = {l_reg.shift[6:0], sda_s};
                                2'h3: begin
                                    l_next.scl_low = 1'h1;
                                    l_next.bitcnt = l_reg.bitcnt + 3'h1;
                                end
                            endcase
                        end
                        // ack: put the ack value, one clock pulse
                        if (l_reg.cmd[`IMS_BIT_ACK]) begin
                            if (l_reg.phase == 2'h0) l_next.sda_low = ~l_reg.ack_val;
                            if (l_reg.phase == 2'h1) l_next.scl_low = 1'h0;
                            if (l_reg.phase == 2'h3) l_next.scl_low = 1'h1;
                        end
                        if (fin) begin
                            l_next.st = IMS_ST_DONE;
                        end
                    end
                end
                IMS_ST_DONE: begin
                    // release data after ack, report completion
                    if (l_reg.cmd[`IMS_BIT_ACK]) begin
                        l_next.sda_low = 1'h0;
                    end
                    l_next.cmd = '0;
                    l_next.done_tgl = ~l_reg.done_tgl;
                    l_next.st = IMS_ST_IDLE;
                end
                default: begin
                    // illegal code: back to idle with lines released
                    l_next.st = IMS_ST_IDLE;
                    l_next.cmd = '0;
                    l_next.scl_low = 1'h0;
                    l_next.sda_low = 1'h0;
                end
            endcase
        end
        if (!l_rst_n) begin
            l_next = '0;
        end
    end

    // link side flip-flops
    always_ff @(posedge link_clk) begin
        l_reg <= l_next;
    end

    // ****************************************************************
    // open-drain pins: output value low, enable pulls the line
    // ****************************************************************
    assign scl_o = 1'h0;
    assign sda_o = 1'h0;
    assign scl_oe = l_reg.scl_low;
    assign sda_oe = l_reg.sda_low;

endmodule : ims_master_seq

// >>> dv/ims_master_seq_monitor.sv
// Purpose: port-level checks of the bus sequencer
// Assumes: lines pulled up, pins open drain
// Notes: bound to every sequencer instance
`timescale 1ns/1ps
`include "ims_params.svh"

module ims_master_seq_monitor
    import ims_pkg::*;
#(
    parameter int QTR_TICKS = `IMS_QTR_TICKS
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [`IMS_ADDR_W-1:0] reg_addr,
    input wire logic [`IMS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`IMS_DATA_W-1:0] reg_rdata,
    input wire logic link_clk,
    input wire logic scl_oe,
    input wire logic sda_oe
);
    // ****************************************
    // helper state and checks
    // ****************************************
    localparam int Q_LO = QTR_TICKS - 1; // quarter bounds
    localparam int Q_HI = QTR_TICKS + 3;
    logic idle_reg; // last ctrl read idle, no write since
    logic idle_next;
    logic rdc_reg; // ctrl read last cycle
    logic rdu_reg; // unmapped read last cycle
    logic [5:0] wd_reg; // last ctrl write low bits
    // idle tracking from ctrl traffic
    always_comb begin
        idle_next = idle_reg;
        if (ce && reg_wr && reg_addr == `IMS_OFS_CTRL) begin
            idle_next = 1'b0;
        end else if (rdc_reg && reg_rdata[4:0] == 5'h00) begin
            idle_next = 1'b1;
        end
    end
    // helper registers
    always_ff @(posedge ref_clk) begin
        idle_reg <= rst_n ? idle_next : 1'b1;
        rdc_reg <= rst_n && ce && reg_rd && reg_addr == `IMS_OFS_CTRL;
        rdu_reg <= rst_n && ce && reg_rd && reg_addr != `IMS_OFS_CTRL
            && reg_addr != `IMS_OFS_RXDATA;
        wd_reg <= (ce && reg_wr && reg_addr == `IMS_OFS_CTRL) ? reg_wdata[5:0] : wd_reg;
    end
    AST_RDATA_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data outside answer");
    AST_CTRL_UNUSED: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rdc_reg |-> reg_rdata[15:6] == 10'h000) else $error("ctrl unused bits set");
    AST_REQ_ONEHOT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rdc_reg |-> $onehot0(reg_rdata[4:0])) else $error("two requests pending");
    AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rdu_reg |-> reg_rdata == 16'h0000) else $error("unmapped read not zero");
    AST_REQ_TAKEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
        idle_reg && ce && reg_wr && reg_addr == `IMS_OFS_CTRL && $onehot(reg_wdata[4:0])
        ##1 ce && reg_rd && reg_addr == `IMS_OFS_CTRL |=> reg_rdata[5:0] == wd_reg)
        else $error("request bit not pending");
    AST_COND_SCL: assert property (@(posedge link_clk) disable iff (!rst_n)
        $rose(sda_oe) && !scl_oe |-> ##[Q_LO:Q_HI] scl_oe) else $error("start not closed");
    AST_STOP_IDLE: assert property (@(posedge link_clk) disable iff (!rst_n)
        $fell(sda_oe) && !scl_oe |=> (!scl_oe && !sda_oe) [*8]) else $error("bus busy after stop");
    AST_SCL_HIGH_MIN: assert property (@(posedge link_clk) disable iff (!rst_n)
        $fell(scl_oe) |=> !scl_oe [*3]) else $error("clock high too short");
    // main scenarios
    cover property (@(posedge link_clk) $rose(sda_oe) && !scl_oe);
    cover property (@(posedge link_clk) $fell(sda_oe) && !scl_oe);
    cover property (@(posedge ref_clk) idle_reg && reg_wr && reg_addr == `IMS_OFS_CTRL);
endmodule : ims_master_seq_monitor

bind ims_master_seq ims_master_seq_monitor #(.QTR_TICKS(QTR_TICKS)) ims_master_seq_monitor_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_clk(link_clk),
    .scl_oe(scl_oe), .sda_oe(sda_oe));

// >>> dv/ims_bus_target.sv
// Purpose: pulled-up two-wire lines with a byte-sending target
// Assumes: master drives open-drain enables
// Notes: target may stretch the clock after each release
`timescale 1ns/1ps

module ims_bus_target (
    input wire logic link_clk,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic arm,
    input wire logic [7:0] tx_byte,
    input wire logic [3:0] stretch,
    output logic scl_line,
    output logic sda_line
);
    // ****************************************
    // wired lines and target state
    // ****************************************
    logic [3:0] hold_reg; // stretch count left
    logic [3:0] idx_reg; // bit being sent
    logic oe_q; // master clock enable, delayed
    logic line_q; // clock line, delayed
    initial begin
        hold_reg = 4'h0;
        idx_reg = 4'h0;
        oe_q = 1'b0;
        line_q = 1'b1;
    end
    // pull-ups win unless someone pulls low
    assign scl_line = !(scl_oe || (oe_q && stretch != 4'h0) || hold_reg != 4'h0);
    assign sda_line = !(sda_oe || (arm && idx_reg < 4'h8 && !tx_byte[3'h7 - idx_reg[2:0]]));
    // stretch after release, advance bit on clock fall
    always @(posedge link_clk) begin
        oe_q <= scl_oe;
        line_q <= scl_line;
        if (oe_q && !scl_oe) begin
            hold_reg <= stretch;
        end else if (hold_reg != 4'h0) begin
            hold_reg <= hold_reg - 4'h1;
        end
        if (!arm) begin
            idx_reg <= 4'h0;
        end else if (line_q && !scl_line) begin
            idx_reg <= idx_reg + 4'h1;
        end
    end
endmodule : ims_bus_target

// >>> dv/ims_master_seq_tb_top.sv
// Purpose: register-level tests of the bus sequencer
// Assumes: short quarter period, target model on the lines
// Notes: each request is polled until it clears
`timescale 1ns/1ps
`include "ims_params.svh"

module ims_master_seq_tb_top;
    import ims_pkg::*;
    // ****************************************
    // signals and instances
    // ****************************************
    logic ref_clk, link_clk, rst_n, ce, reg_wr, reg_rd, arm, scl_q, ack_seen;
    logic scl_o, scl_oe, sda_o, sda_oe, scl_line, sda_line;
    logic [`IMS_ADDR_W-1:0] reg_addr;
    logic [`IMS_DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
    logic [7:0] tx_byte;
    logic [3:0] stretch;
    int num_errors = 0;
    int total_checks = 0;
    ims_master_seq #(.QTR_TICKS(4)) ims_master_seq_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .link_clk(link_clk), .scl_in(scl_line), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_in(sda_line), .sda_o(sda_o), .sda_oe(sda_oe));
    ims_bus_target ims_bus_target_inst (.link_clk(link_clk), .scl_oe(scl_oe), .sda_oe(sda_oe),
        .arm(arm), .tx_byte(tx_byte), .stretch(stretch), .scl_line(scl_line),
        .sda_line(sda_line));
    // clocks, unrelated phases
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #16 link_clk = ~link_clk;
    end
    // data line seen at each clock rise
    always @(posedge link_clk) begin
        scl_q <= scl_line;
        if (scl_line && !scl_q) begin
            ack_seen <= sda_line;
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask : reg_read
    task automatic wait_clear(input int b);
        int n;
        n = 0;
        do begin
            reg_read(`IMS_OFS_CTRL, rd_val);
            n++;
        end while (rd_val[b] !== 1'b0 && n < 300);
    endtask : wait_clear
    task automatic run_req(input int b, input logic av);
        logic [15:0] req;
        req = 16'h0000;
        req[b] = 1'b1;
        req[`IMS_BIT_ACKVAL] = av;
        reg_write(`IMS_OFS_CTRL, req);
        reg_read(`IMS_OFS_CTRL, rd_val);
        check(rd_val, req);
        wait_clear(b);
        check(rd_val, {10'h000, av, 5'h00});
    endtask : run_req
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    // ****************************************
    // tests
    // ****************************************
    initial begin
        {ce, rst_n, reg_wr, reg_rd, arm} = 5'b10000;
        {reg_addr, reg_wdata, tx_byte, stretch} = '0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        reg_read(`IMS_OFS_CTRL, rd_val);
        check(rd_val, `IMS_CTRL_RESET);
        reg_read(`IMS_OFS_RXDATA, rd_val);
        check(rd_val, {8'h00, `IMS_RXDATA_RESET});
        reg_write(4'h4, 16'hffff);
        reg_read(4'h4, rd_val);
        check(rd_val, 16'h0000);
        reg_write(`IMS_OFS_CTRL, 16'h0003);
        reg_read(`IMS_OFS_CTRL, rd_val);
        check(rd_val, 16'h0000);
        check({14'h0000, scl_line, sda_line}, 16'h0003);
        // frozen block ignores a start request and keeps read data
        @(posedge ref_clk);
        ce <= 1'b0;
        reg_write(`IMS_OFS_CTRL, 16'h0001);
        reg_read(`IMS_OFS_CTRL, rd_val);
        check(rd_val, 16'h0000);
        @(posedge ref_clk);
        ce <= 1'b1;
        reg_read(`IMS_OFS_CTRL, rd_val);
        check(rd_val, 16'h0000);
        check({14'h0000, scl_o, sda_o}, 16'h0000);
        $display("test reset_and_refusal done");
        run_req(`IMS_BIT_START, 1'b0);
        check({14'h0000, scl_line, sda_line}, 16'h0000);
        $display("test start done");
        for (int i = 0; i < 2; i++) begin
            tx_byte <= (i == 0) ? 8'ha5 : 8'h3c;
            stretch <= (i == 0) ? 4'h3 : 4'h0;
            arm <= 1'b1;
            reg_write(`IMS_OFS_CTRL, 16'h0008);
            reg_write(`IMS_OFS_CTRL, 16'h0004);
            reg_read(`IMS_OFS_CTRL, rd_val);
            check(rd_val, 16'h0008);
            wait_clear(`IMS_BIT_RECV);
            check(rd_val, 16'h0000);
            reg_read(`IMS_OFS_RXDATA, rd_val);
            check(rd_val, {8'h00, tx_byte});
            arm <= 1'b0;
            run_req(`IMS_BIT_ACK, i == 0);
            check({15'h0000, ack_seen}, (i == 0) ? 16'h0001 : 16'h0000);
            if (i == 0) begin
                run_req(`IMS_BIT_RESTART, 1'b0);
                check({14'h0000, scl_line, sda_line}, 16'h0000);
            end
            $display("test receive_ack %0d done", i);
        end
        run_req(`IMS_BIT_STOP, 1'b0);
        check({14'h0000, scl_line, sda_line}, 16'h0003);
        $display("test stop done");
        tally_and_finish();
    end
    // hang guard, well beyond the expected run
    initial begin
        #200_000;
        num_errors++;
        tally_and_finish();
    end
endmodule : ims_master_seq_tb_top
